// ### shared/adc_seq_consts.vh
// Constants for the serial control byte sequencer
`ifndef ADC_SEQ_CONSTS_VH
`define ADC_SEQ_CONSTS_VH
`define START_POS         7
`define CHSEL_HI_POS      6
`define CHSEL_MID_POS     5
`define CHSEL_LO_POS      4
`define POLARITY_POS      3
`define INCFG_POS         2
`define PWR_HI_POS        1
`define PWR_LO_POS        0
`define CTRL_RESET        8'h00
`define PWR_FULL_DOWN     2'h0
`define PWR_EXT_CLOCK     2'h3
`define TRACK_BIT_COUNT   4'h5
`define HOLD_BIT_COUNT    4'h8
`define RESULT_BITS       4'hc
`define FRAME_BITS        5'h10
`define MUX_COM           3'h4
`define MUX_NONE          3'h7
`endif

// ### src/adc_result_fifo.v
// Result word buffer with valid and ready on both sides
module adc_result_fifo #(
  parameter WIDTH = 12,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst_n,
  // Fill side
  input  wire             in_valid,
  output wire             in_ready,
  input  wire [WIDTH-1:0] in_data,
  // Drain side
  output wire             out_valid,
  input  wire             out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
  reg [AW-1:0]    wr_ptr_reg;
  reg [AW-1:0]    rd_ptr_reg;
  reg [AW:0]      count_reg;
  wire            do_wr;
  wire            do_rd;
  assign in_ready  = (count_reg != DEPTH[AW:0]);
  assign out_valid = (count_reg != {(AW+1){1'b0}});
  assign out_data  = mem_reg[rd_ptr_reg];
  assign do_wr     = in_valid && in_ready;
  assign do_rd     = out_valid && out_ready;
  always @(posedge clk_sys) begin
    if (do_wr) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr_reg <= {AW{1'b0}};
      rd_ptr_reg <= {AW{1'b0}};
      count_reg  <= {(AW+1){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_reg <= (wr_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      wr_ptr_reg + 1'b1;
      end
      if (do_rd) begin
        rd_ptr_reg <= (rd_ptr_reg == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} :
                      rd_ptr_reg + 1'b1;
      end
      if (do_wr && !do_rd) begin
        count_reg <= count_reg + 1'b1;
      end else if (do_rd && !do_wr) begin
        count_reg <= count_reg - 1'b1;
      end
    end
  end
endmodule

// ### src/adc_serial_control_byte_sequencer.v
// Serial control path of a four-channel 12-bit converter
`include "adc_seq_consts.vh"
module adc_serial_control_byte_sequencer #(
  parameter RES_W = 12,
  parameter DEPTH = 32
) (
  // Clock and reset
  input  wire             clk_sys,
  input  wire             rst_b,
  // Serial pins
  input  wire             sclk,
  input  wire             cs_b,
  input  wire             din,
  output reg              dout_o,
  output reg              dout_oe_b,
  output reg              conversion_strobe_o,
  output reg              conversion_strobe_oe_b,
  // Converter core result words
  input  wire             sample_valid,
  output wire             sample_ready,
  input  wire [RES_W-1:0] sample_data,
  // Analog switch control
  output reg  [2:0]       positive_input,
  output reg  [2:0]       negative_input,
  output reg              track_hold,
  output reg              hold_capacitor_on_pos,
  output reg              unipolar,
  output reg              single_ended,
  output reg  [1:0]       power_clock_mode,
  output reg  [7:0]       conversion_control_word,
  output reg              converting
);
  localparam ST_IDLE = 2'h0;
  localparam ST_CTRL = 2'h1;
  localparam ST_CONV = 2'h2;
  localparam ST_DONE = 2'h3;

  reg             rst_s1_reg;
  reg             rst_n_reg;
  reg [2:0]       sclk_sync_reg;
  reg [1:0]       cs_sync_reg;
  reg [1:0]       din_sync_reg;
  reg [1:0]       state_reg;
  reg [3:0]       bit_cnt_reg;
  reg [4:0]       out_cnt_reg;
  reg [7:0]       shift_reg;
  reg [15:0]      tx_reg;
  reg             have_result_reg;
  wire            rise;
  wire            fall;
  wire            cs_low;
  wire            din_s;
  wire            fifo_valid;
  wire [RES_W-1:0] fifo_data;
  wire            take_result;
  wire [7:0]      ctrl_word;
  wire [2:0]      sel;
  reg  [2:0]      pos_next;
  reg  [2:0]      neg_next;

  always @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      rst_s1_reg <= 1'b0;
      rst_n_reg  <= 1'b0;
    end else begin
      rst_s1_reg <= 1'b1;
      rst_n_reg  <= rst_s1_reg;
    end
  end

  always @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sclk_sync_reg <= 3'h0;
      cs_sync_reg   <= 2'h3;
      din_sync_reg  <= 2'h0;
    end else begin
      sclk_sync_reg <= {sclk_sync_reg[1:0], sclk};
      cs_sync_reg   <= {cs_sync_reg[0], cs_b};
      din_sync_reg  <= {din_sync_reg[0], din};
    end
  end
  assign rise   = sclk_sync_reg[1] && !sclk_sync_reg[2];
  assign fall   = !sclk_sync_reg[1] && sclk_sync_reg[2];
  assign cs_low = !cs_sync_reg[1];
  assign din_s  = din_sync_reg[1];

  adc_result_fifo #(
    .WIDTH (RES_W),
    .DEPTH (DEPTH),
    .AW    (5)
  ) u_fifo (
    .clk_sys   (clk_sys),
    .rst_n     (rst_n_reg),
    .in_valid  (sample_valid),
    .in_ready  (sample_ready),
    .in_data   (sample_data),
    .out_valid (fifo_valid),
    .out_ready (take_result),
    .out_data  (fifo_data)
  );

  // Control word assembled from the shifted bits plus the current bit
  assign ctrl_word = {shift_reg[6:0], din_s};
  assign sel       = {ctrl_word[`CHSEL_HI_POS], ctrl_word[`CHSEL_MID_POS],
                      ctrl_word[`CHSEL_LO_POS]};
  assign take_result = fifo_valid && state_reg == ST_CONV && fall &&
                       out_cnt_reg == 5'h0 && !have_result_reg;

  // Channel mux decode
  always @* begin
    pos_next = 3'h0;
    neg_next = `MUX_COM;
    if (ctrl_word[`INCFG_POS]) begin
      neg_next = `MUX_COM;
      case (sel)
        3'h1: pos_next = 3'h0;
        3'h5: pos_next = 3'h1;
        3'h2: pos_next = 3'h2;
        3'h6: pos_next = 3'h3;
        default: pos_next = 3'h0;
      endcase
    end else begin
      case (sel)
        3'h1: begin
          pos_next = 3'h0;
          neg_next = 3'h1;
        end
        3'h2: begin
          pos_next = 3'h2;
          neg_next = 3'h3;
        end
        3'h5: begin
          pos_next = 3'h1;
          neg_next = 3'h0;
        end
        3'h6: begin
          pos_next = 3'h3;
          neg_next = 3'h2;
        end
        default: begin
          pos_next = 3'h0;
          neg_next = 3'h1;
        end
      endcase
    end
  end

  always @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      state_reg               <= ST_IDLE;
      bit_cnt_reg             <= 4'h0;
      out_cnt_reg             <= 5'h0;
      shift_reg               <= `CTRL_RESET;
      tx_reg                  <= 16'h0000;
      have_result_reg         <= 1'b0;
      dout_o                  <= 1'b0;
      dout_oe_b               <= 1'b1;
      conversion_strobe_o     <= 1'b0;
      conversion_strobe_oe_b  <= 1'b1;
      positive_input          <= 3'h0;
      negative_input          <= `MUX_COM;
      track_hold              <= 1'b0;
      hold_capacitor_on_pos   <= 1'b1;
      unipolar                <= 1'b1;
      single_ended            <= 1'b1;
      power_clock_mode        <= `PWR_EXT_CLOCK;
      conversion_control_word <= `CTRL_RESET;
      converting              <= 1'b0;
    end else begin
      dout_oe_b              <= !cs_low;
      conversion_strobe_oe_b <= !cs_low;
      if (!cs_low) begin
        state_reg           <= ST_IDLE;
        bit_cnt_reg         <= 4'h0;
        conversion_strobe_o <= 1'b0;
        converting          <= 1'b0;
        track_hold          <= 1'b0;
        dout_o              <= 1'b0;
        // A cut frame still hands the capacitor back
        hold_capacitor_on_pos <= 1'b1;
      end else begin
        case (state_reg)
          ST_IDLE: begin
            if (rise && din_s) begin
              shift_reg   <= 8'h01;
              bit_cnt_reg <= 4'h1;
              state_reg   <= ST_CTRL;
            end
          end
          ST_CTRL: begin
            if (rise) begin
              shift_reg   <= ctrl_word;
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
            if (fall && bit_cnt_reg == `TRACK_BIT_COUNT) begin
              track_hold            <= 1'b1;
              hold_capacitor_on_pos <= 1'b1;
            end
            if (rise && bit_cnt_reg == `HOLD_BIT_COUNT - 4'h1) begin
              // Decode of the full control word
              conversion_control_word <= ctrl_word;
              unipolar          <= ctrl_word[`POLARITY_POS];
              single_ended      <= ctrl_word[`INCFG_POS];
              power_clock_mode  <= ctrl_word[`PWR_HI_POS:`PWR_LO_POS];
              positive_input    <= pos_next;
              negative_input    <= neg_next;
            end
            if (fall && bit_cnt_reg == `HOLD_BIT_COUNT) begin
              track_hold            <= 1'b0;
              hold_capacitor_on_pos <= 1'b0;
              bit_cnt_reg           <= 4'h0;
              out_cnt_reg           <= 5'h0;
              tx_reg                <= 16'h0000;
              have_result_reg       <= 1'b0;
              dout_o                <= 1'b0;
              if (power_clock_mode == `PWR_FULL_DOWN) begin
                state_reg <= ST_IDLE;
              end else begin
                state_reg           <= ST_CONV;
                converting          <= 1'b1;
                conversion_strobe_o <=
                  (power_clock_mode == `PWR_EXT_CLOCK);
              end
            end
          end
          ST_CONV: begin
            if (fall) begin
              conversion_strobe_o <= 1'b0;
              if (out_cnt_reg == 5'h0) begin
                // First fall after hold puts the MSB out
                if (take_result) begin
                  dout_o          <= fifo_data[RES_W-1];
                  tx_reg          <= {fifo_data[RES_W-2:0], 5'h00};
                  have_result_reg <= 1'b1;
                end
              end else begin
                dout_o <= tx_reg[15];
                tx_reg <= {tx_reg[14:0], 1'b0};
              end
              out_cnt_reg <= out_cnt_reg + 5'h1;
              if (out_cnt_reg == {1'b0, `RESULT_BITS - 4'h1}) begin
                // Last bit decision made, conversion over
                converting            <= 1'b0;
                hold_capacitor_on_pos <= 1'b1;
                state_reg             <= ST_DONE;
              end
            end
          end
          ST_DONE: begin
            if (fall) begin
              // Trailing zeros of the result bytes
              dout_o      <= 1'b0;
              out_cnt_reg <= out_cnt_reg + 5'h1;
              if (out_cnt_reg == `FRAME_BITS - 5'h1) begin
                state_reg <= ST_IDLE;
              end
            end
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ### sim/adc_seq_chk.sv
// Concurrent checks on the sequencer top-level ports
module adc_seq_chk (
  input logic       clk_sys,
  input logic       rst_b,
  input logic       sclk,
  input logic       cs_b,
  input logic       dout_o,
  input logic       dout_oe_b,
  input logic       conversion_strobe_o,
  input logic       conversion_strobe_oe_b,
  input logic [2:0] positive_input,
  input logic [2:0] negative_input,
  input logic       track_hold,
  input logic       hold_capacitor_on_pos,
  input logic       single_ended,
  input logic [1:0] power_clock_mode,
  input logic       converting
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_oe_released: assert property (
    cs_b [*4] |-> dout_oe_b && conversion_strobe_oe_b)
    else $error("serial outputs driven while deselected");
  a_dout_on_fall: assert property (
    !dout_oe_b && $changed(dout_o) |-> !sclk)
    else $error("data output moved while serial clock high");
  a_track_on_fall: assert property ($rose(track_hold) |-> !sclk)
    else $error("tracking began away from a falling edge");
  a_track_bounded: assert property (
    $rose(track_hold) |-> ##[1:400] $fell(track_hold))
    else $error("hold phase never began");
  a_conv_start: assert property ($rose(converting) |->
    !track_hold && power_clock_mode != 2'h0 && conversion_strobe_o)
    else $error("conversion start out of step");
  a_strobe_pulse: assert property ($rose(conversion_strobe_o) |->
    conversion_strobe_o [*8] ##[1:4] !conversion_strobe_o)
    else $error("strobe width not one serial period");
  a_conv_span: assert property (
    $rose(converting) |-> ##110 converting ##20 !converting)
    else $error("conversion span not twelve serial periods");
  a_cap_return: assert property (
    $fell(converting) |-> hold_capacitor_on_pos)
    else $error("hold capacitor not back on positive input");
  a_se_common: assert property (
    $rose(converting) && single_ended |-> negative_input == 3'h4)
    else $error("single-ended minus side not common return");
  a_diff_pair: assert property ($rose(converting) &&
    !single_ended |-> negative_input == (positive_input ^ 3'h1))
    else $error("differential minus side not the pair partner");
endmodule

bind adc_serial_control_byte_sequencer adc_seq_chk i_adc_seq_chk (
  .clk_sys, .rst_b, .sclk, .cs_b, .dout_o, .dout_oe_b,
  .conversion_strobe_o, .conversion_strobe_oe_b, .positive_input,
  .negative_input, .track_hold, .hold_capacitor_on_pos, .single_ended,
  .power_clock_mode, .converting);

// ### sim/serial_master_model.sv
// Serial master model driving select, clock and data
module serial_master_model (
  input  logic clk_sys,
  input  logic dout_o,
  output logic sclk,
  output logic cs_b,
  output logic din
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int ACQ = 188;
  initial begin
    sclk = 1'b0;
    cs_b = 1'b1;
    din  = 1'b0;
  end
  task automatic bit_io(input logic b, output logic r);
    din = b;
    repeat (5) @(negedge clk_sys);
    r    = dout_o;
    sclk = 1'b1;
    repeat (5) @(negedge clk_sys);
    sclk = 1'b0;
  endtask
  task automatic frame(input int zeros, input logic [7:0] tb,
                       output logic [15:0] rx);
    logic       r;
    logic [7:0] r1;
    @(negedge clk_sys);
    cs_b = 1'b0;
    repeat (zeros) bit_io(1'b0, r);
    for (int i = 7; i >= 0; i--) begin
      bit_io(tb[i], r1[i]);
      if (i == 3) repeat (ACQ) @(negedge clk_sys);
    end
    for (int i = 15; i >= 0; i--) bit_io(1'b0, rx[i]);
    repeat (2) @(negedge clk_sys);
    cs_b = 1'b1;
    din  = ~din;
    repeat (8) @(negedge clk_sys);
  endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the serial control byte sequencer
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clk_sys, rst_b, sample_valid;
  logic [11:0] sample_data;
  logic [7:0]  ctl;
  logic [15:0] rx;
  logic [11:0] exp_q[$];
  int          miscompares, tests_run;
  wire         sclk, cs_b, din, dout_o, dout_oe_b, sample_ready;
  wire         conversion_strobe_o, conversion_strobe_oe_b, converting;
  wire         track_hold, hold_capacitor_on_pos, unipolar, single_ended;
  wire [2:0]   positive_input, negative_input;
  wire [1:0]   power_clock_mode;
  wire [7:0]   conversion_control_word;
  adc_serial_control_byte_sequencer i_adc_serial_control_byte_sequencer (
    .clk_sys, .rst_b, .sclk, .cs_b, .din, .dout_o, .dout_oe_b,
    .conversion_strobe_o, .conversion_strobe_oe_b, .sample_valid,
    .sample_ready, .sample_data, .positive_input, .negative_input,
    .track_hold, .hold_capacitor_on_pos, .unipolar, .single_ended,
    .power_clock_mode, .conversion_control_word, .converting);
  serial_master_model i_serial_master_model (
    .clk_sys, .dout_o, .sclk, .cs_b, .din);
  initial begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] want);
    tests_run++;
    if (seen !== want) begin
      miscompares++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask
  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic push(input logic [11:0] d);
    @(negedge clk_sys);
    sample_valid = 1'b1;
    sample_data  = d;
    do @(posedge clk_sys); while (sample_ready !== 1'b1);
    @(negedge clk_sys);
    sample_valid = 1'b0;
    exp_q.push_back(d);
  endtask
  // Expected positive and negative selection for a control byte
  function automatic logic [5:0] route(input logic [7:0] c);
    case ({c[2], c[6:4]})
      4'b1001: route = {3'h0, 3'h4};
      4'b1101: route = {3'h1, 3'h4};
      4'b1010: route = {3'h2, 3'h4};
      4'b1110: route = {3'h3, 3'h4};
      4'b0010: route = {3'h2, 3'h3};
      4'b0101: route = {3'h1, 3'h0};
      4'b0110: route = {3'h3, 3'h2};
      default: route = c[2] ? {3'h0, 3'h4} : {3'h0, 3'h1};
    endcase
  endfunction
  initial begin
    #400000;
    miscompares++;
    close_out();
  end
  initial begin
    rst_b        = 1'b0;
    sample_valid = 1'b0;
    sample_data  = 12'h000;
    miscompares  = 0;
    tests_run    = 0;
    void'($urandom(41165));
    repeat (12) @(negedge clk_sys);
    rst_b = 1'b1;
    repeat (4) @(negedge clk_sys);
    check({2'h0, power_clock_mode, conversion_control_word, track_hold,
           hold_capacitor_on_pos, dout_oe_b, conversion_strobe_oe_b},
          {2'h0, 2'h3, 8'h00, 4'b0111});
    for (int i = 0; i < 32; i++) push(12'($urandom));
    @(negedge clk_sys);
    sample_valid = 1'b1;
    @(negedge clk_sys);
    check({15'h0, sample_ready}, 16'h0000);
    sample_valid = 1'b0;
    for (int i = 0; i < 33; i++) begin
      ctl = {1'b1, i[2:0], 1'($urandom), i[3], (i < 32) ? 2'h3 : 2'h0};
      i_serial_master_model.frame($urandom_range(3), ctl, rx);
      check({8'h0, conversion_control_word}, {8'h0, ctl});
      check({12'h0, unipolar, single_ended, power_clock_mode},
            {12'h0, ctl[3:0]});
      check({10'h0, positive_input, negative_input},
            {10'h0, route(ctl)});
      check({10'h0, converting, track_hold, conversion_strobe_o, dout_oe_b,
             conversion_strobe_oe_b, hold_capacitor_on_pos},
            16'h0007);
      if (i < 32)
        check(rx, {1'b0, exp_q.pop_front(), 3'h0});
    end
    check({15'h0, sample_ready}, 16'h0001);
    close_out();
  end
endmodule
